//--- verilog/sfr_front.sv
// Command decoder and array read engine of a serial flash behind an SPI pin set.
`timescale 1ns/100ps
// Operation
// - Fast read takes three address, two dummy bytes.
// - Standard read takes one dummy byte.
// - Slow read has no dummy bytes.
// - Address counter advances for continuous stream.
// - Single read drives output MSB first.
// - Top address wraps to zero without delay.
// - Chip select high floats output at once.
// - Dual read: opcode, address, one dummy byte.
// - Dual read sends two bits per clock.
// - Chip select high floats both data lines.
// - Page program: address, no dummy, data.
// - Status byte one write: one data byte.
// - Security area read: address, two dummies.
// - Security area program: address, no dummy.
// - Protection read: address, no dummy, data.
// - Lockdown read: address, no dummy, data.
// - Freeze lockdown: address, one data byte.
// - Identification read returns one to four bytes; the code floats the output after the MSB of the fourth.
// - Power down and wake are bare opcodes.
// - Unknown opcode ignored until chip select cycles.
// - Early chip select rise returns to idle.
// - Address MSB first, top three bits ignored.
// - Sample on rising, change on falling edge.
module sfr_front #(
  parameter int ADDR_W = sfr_pkg::ADDR_W
) (
  // Clock, enable and reset.
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  // SPI pins from the master.
  input  wire logic              cs_b_pin,
  input  wire logic              sck_pin,
  input  wire logic              si_pin,
  // Serial output pin.
  output logic                   so_out,
  output logic                   so_oe,
  // Second data line, input during commands and output in dual read.
  output logic                   second_data_line_out,
  output logic                   second_data_line_oe,
  // Array read port; data for the address must be valid one clock after.
  output logic [ADDR_W-1:0]      array_addr,
  input  wire logic [7:0]        array_data,
  // Decoded command towards the rest of the device.
  output logic [7:0]             cmd_opcode,
  output logic [23:0]            cmd_addr,
  output logic                   cmd_start,
  output logic [7:0]             cmd_wdata,
  output logic                   cmd_wvalid,
  output logic                   cmd_end,
  // Byte to shift out for register style reads (status, id, security, protection, lockdown).
  input  wire logic [7:0]        aux_rdata,
  output logic                   aux_rnext
);

  // Three-stage pin synchronisers; for chip select and clock, stages 1 and 2 must agree before a level is taken.
  logic [2:0] cs_sync_ff;
  logic [2:0] sck_sync_ff;
  logic [2:0] si_sync_ff;
  logic       cs_b_ff;
  logic       sck_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync_ff  <= 3'h7;
      sck_sync_ff <= 3'h0;
      si_sync_ff  <= 3'h0;
      cs_b_ff     <= 1'b1;
      sck_ff      <= 1'b0;
    end else if (clk_en) begin
      cs_sync_ff  <= {cs_sync_ff[1:0], cs_b_pin};
      sck_sync_ff <= {sck_sync_ff[1:0], sck_pin};
      si_sync_ff  <= {si_sync_ff[1:0], si_pin};
      if (cs_sync_ff[1] == cs_sync_ff[2]) begin
        cs_b_ff <= cs_sync_ff[2];
      end
      if (sck_sync_ff[1] == sck_sync_ff[2]) begin
        sck_ff <= sck_sync_ff[2];
      end
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic sel;
  logic desel;
  logic si_bit;

  // Clock edges are judged on the filtered copy so a glitch counts once.
  assign sel      = !cs_b_ff;
  assign sck_rise = sel && (sck_sync_ff[1] == sck_sync_ff[2]) && sck_sync_ff[2] && !sck_ff;
  assign sck_fall = sel && (sck_sync_ff[1] == sck_sync_ff[2]) && !sck_sync_ff[2] && sck_ff;
  assign desel    = (cs_sync_ff[1] == cs_sync_ff[2]) && cs_sync_ff[2];
  assign si_bit   = si_sync_ff[2];

  // Dummy byte count for an opcode; any opcode not listed gets none.
  function automatic logic [1:0] dummy_of(input logic [7:0] op);
    unique case (op)
      sfr_pkg::OP_READ_FAST, sfr_pkg::OP_OTP_READ: dummy_of = sfr_pkg::DUMMY_TWO;
      sfr_pkg::OP_READ_STD, sfr_pkg::OP_READ_DUAL: dummy_of = sfr_pkg::DUMMY_ONE;
      default:                                       dummy_of = sfr_pkg::DUMMY_NONE;
    endcase
  endfunction

  // Whether an opcode is followed by three address bytes.
  function automatic logic has_addr(input logic [7:0] op);
    case (op)
      sfr_pkg::OP_READ_FAST, sfr_pkg::OP_READ_STD, sfr_pkg::OP_READ_SLOW,
      sfr_pkg::OP_READ_DUAL, sfr_pkg::OP_PAGE_PROG, sfr_pkg::OP_DUAL_PROG,
      sfr_pkg::OP_OTP_READ, sfr_pkg::OP_OTP_PROG, sfr_pkg::OP_RD_PROT,
      sfr_pkg::OP_RD_LOCK, sfr_pkg::OP_LOCKDOWN, sfr_pkg::OP_FREEZE,
      sfr_pkg::OP_PROTECT, sfr_pkg::OP_UNPROTECT, sfr_pkg::OP_ERASE_4K,
      sfr_pkg::OP_ERASE_32K, sfr_pkg::OP_ERASE_64K: has_addr = 1'b1;
      default: has_addr = 1'b0;
    endcase
  endfunction

  // Operation class of an opcode; an unsupported code maps to none.
  function automatic sfr_pkg::sfr_kind_e kind_of(input logic [7:0] op);
    case (op)
      sfr_pkg::OP_READ_FAST, sfr_pkg::OP_READ_STD,
      sfr_pkg::OP_READ_SLOW:                         kind_of = sfr_pkg::SFR_KIND_READ;
      sfr_pkg::OP_READ_DUAL:                         kind_of = sfr_pkg::SFR_KIND_DUAL;
      sfr_pkg::OP_PAGE_PROG, sfr_pkg::OP_DUAL_PROG, sfr_pkg::OP_OTP_PROG,
      sfr_pkg::OP_WR_STAT1, sfr_pkg::OP_WR_STAT2, sfr_pkg::OP_LOCKDOWN,
      sfr_pkg::OP_FREEZE, sfr_pkg::OP_SOFT_RESET:    kind_of = sfr_pkg::SFR_KIND_WRITE;
      sfr_pkg::OP_OTP_READ, sfr_pkg::OP_RD_PROT, sfr_pkg::OP_RD_LOCK,
      sfr_pkg::OP_RD_STAT, sfr_pkg::OP_READ_ID:      kind_of = sfr_pkg::SFR_KIND_AUX_RD;
      sfr_pkg::OP_ERASE_4K, sfr_pkg::OP_ERASE_32K, sfr_pkg::OP_ERASE_64K,
      sfr_pkg::OP_CHIP_ER_A, sfr_pkg::OP_CHIP_ER_B, sfr_pkg::OP_SUSPEND,
      sfr_pkg::OP_RESUME, sfr_pkg::OP_WR_EN, sfr_pkg::OP_WR_DIS,
      sfr_pkg::OP_PROTECT, sfr_pkg::OP_UNPROTECT,
      sfr_pkg::OP_POWER_DOWN, sfr_pkg::OP_POWER_UP:  kind_of = sfr_pkg::SFR_KIND_BARE;
      default:                                       kind_of = sfr_pkg::SFR_KIND_NONE;
    endcase
  endfunction

  sfr_pkg::sfr_phase_e phase_ff;
  sfr_pkg::sfr_kind_e  kind_ff;
  logic [2:0]          bit_cnt_ff;
  logic [1:0]          byte_cnt_ff;
  logic [7:0]          shift_ff;
  logic [ADDR_W-1:0]   addr_ff;
  logic [7:0]          out_byte_ff;
  logic [2:0]          id_cnt_ff;
  logic [7:0]          nxt_shift;
  logic                byte_done;
  logic                setup_last;
  logic [ADDR_W-1:0]   full_addr;

  assign nxt_shift = {shift_ff[6:0], si_bit};
  assign byte_done = sck_rise && (bit_cnt_ff == sfr_pkg::BIT_LAST);

  // The last address byte is still in the shifter when the address phase
  // ends, so the array address is built from it directly.
  assign full_addr = {cmd_addr[ADDR_W-9:0], nxt_shift};

  // True on the byte that completes opcode, address and dummies of a known
  // command, which is the moment the core may start acting on it.
  always_comb begin
    setup_last = 1'b0;
    if (byte_done) begin
      unique case (phase_ff)
        sfr_pkg::SFR_SETUP_OPCODE: begin
          setup_last = kind_of(nxt_shift) != sfr_pkg::SFR_KIND_NONE && !has_addr(nxt_shift);
        end
        sfr_pkg::SFR_SETUP_ADDR: begin
          setup_last = byte_cnt_ff == sfr_pkg::ADDR_BYTES - 2'h1
                       && dummy_of(cmd_opcode) == sfr_pkg::DUMMY_NONE;
        end
        sfr_pkg::SFR_SETUP_DUMMY: begin
          setup_last = byte_cnt_ff == dummy_of(cmd_opcode) - 2'h1;
        end
        default: begin
          setup_last = 1'b0;
        end
      endcase
    end
  end

  // Input framing: opcode, address, dummy, then data bytes.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_ff    <= sfr_pkg::SFR_SETUP_IDLE;
      kind_ff     <= sfr_pkg::SFR_KIND_NONE;
      bit_cnt_ff  <= 3'h0;
      byte_cnt_ff <= 2'h0;
      shift_ff    <= 8'h0;
      cmd_opcode  <= 8'h0;
      cmd_addr    <= 24'h0;
    end else if (clk_en) begin
      // Any deselect abandons the frame, complete or not.
      if (desel) begin
        phase_ff    <= sfr_pkg::SFR_SETUP_IDLE;
        kind_ff     <= sfr_pkg::SFR_KIND_NONE;
        bit_cnt_ff  <= 3'h0;
        byte_cnt_ff <= 2'h0;
      end else begin
        if (phase_ff == sfr_pkg::SFR_SETUP_IDLE && sel) begin
          phase_ff <= sfr_pkg::SFR_SETUP_OPCODE;
        end
        if (sck_rise) begin
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
          shift_ff   <= nxt_shift;
        end
        if (byte_done) begin
          unique case (phase_ff)
            sfr_pkg::SFR_SETUP_OPCODE: begin
              cmd_opcode  <= nxt_shift;
              kind_ff     <= kind_of(nxt_shift);
              byte_cnt_ff <= 2'h0;
              if (kind_of(nxt_shift) == sfr_pkg::SFR_KIND_NONE) begin
                phase_ff <= sfr_pkg::SFR_SETUP_IGNORE;
              end else if (has_addr(nxt_shift)) begin
                phase_ff <= sfr_pkg::SFR_SETUP_ADDR;
              end else begin
                phase_ff <= sfr_pkg::SFR_SETUP_DATA;
              end
            end
            sfr_pkg::SFR_SETUP_ADDR: begin
              cmd_addr    <= {cmd_addr[15:0], nxt_shift};
              byte_cnt_ff <= byte_cnt_ff + 2'h1;
              if (byte_cnt_ff == sfr_pkg::ADDR_BYTES - 2'h1) begin
                byte_cnt_ff <= 2'h0;
                phase_ff    <= (dummy_of(cmd_opcode) == sfr_pkg::DUMMY_NONE)
                               ? sfr_pkg::SFR_SETUP_DATA : sfr_pkg::SFR_SETUP_DUMMY;
              end
            end
            sfr_pkg::SFR_SETUP_DUMMY: begin
              byte_cnt_ff <= byte_cnt_ff + 2'h1;
              if (byte_cnt_ff == dummy_of(cmd_opcode) - 2'h1) begin
                phase_ff <= sfr_pkg::SFR_SETUP_DATA;
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Command strobes towards the device core.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_start  <= 1'b0;
      cmd_wdata  <= 8'h0;
      cmd_wvalid <= 1'b0;
      cmd_end    <= 1'b0;
    end else if (clk_en) begin
      cmd_start  <= !desel && setup_last;
      cmd_wvalid <= !desel && byte_done && phase_ff == sfr_pkg::SFR_SETUP_DATA
                    && kind_ff == sfr_pkg::SFR_KIND_WRITE;
      if (byte_done) begin
        cmd_wdata <= nxt_shift;
      end
      // A deselect only counts as an end once a known opcode was taken.
      cmd_end    <= desel && phase_ff != sfr_pkg::SFR_SETUP_IDLE
                    && phase_ff != sfr_pkg::SFR_SETUP_OPCODE
                    && phase_ff != sfr_pkg::SFR_SETUP_IGNORE;
    end
  end

  logic rd_phase;
  logic dual;
  logic aux;
  logic [7:0] src_byte;
  logic id_done;
  assign rd_phase = phase_ff == sfr_pkg::SFR_SETUP_DATA;
  assign dual     = kind_ff == sfr_pkg::SFR_KIND_DUAL;
  assign aux      = kind_ff == sfr_pkg::SFR_KIND_AUX_RD;
  // Register style reads take their byte from outside, array reads from the array.
  assign src_byte = aux ? aux_rdata : array_data;
  // The identification read drives three bytes and the MSB of the fourth; past that the pin floats.
  assign id_done  = aux && cmd_opcode == sfr_pkg::OP_READ_ID
                    && id_cnt_ff == sfr_pkg::ID_MAX_BYTES;

  // Output byte, address counter and output pins. The address is loaded
  // when the last setup byte lands, so the array has a clock to answer
  // before the first falling edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_ff              <= '0;
      out_byte_ff          <= 8'h0;
      id_cnt_ff            <= sfr_pkg::IDLE_LEN;
      so_out               <= 1'b0;
      so_oe                <= 1'b0;
      second_data_line_out <= 1'b0;
      second_data_line_oe  <= 1'b0;
      aux_rnext            <= 1'b0;
    end else if (clk_en) begin
      // The request for the next register byte is a one-cycle pulse.
      aux_rnext <= 1'b0;
      if (desel || !rd_phase) begin
        so_oe               <= 1'b0;
        second_data_line_oe <= 1'b0;
        id_cnt_ff           <= sfr_pkg::IDLE_LEN;
        if (byte_done && phase_ff == sfr_pkg::SFR_SETUP_ADDR) begin
          addr_ff <= full_addr;
        end else begin
          addr_ff <= cmd_addr[ADDR_W-1:0];
        end
      end else if (sck_fall) begin
        if (kind_ff == sfr_pkg::SFR_KIND_READ || aux) begin
          so_oe <= !id_done;
          if (bit_cnt_ff == 3'h0) begin
            so_out      <= src_byte[7];
            out_byte_ff <= {src_byte[6:0], 1'b0};
            addr_ff     <= addr_ff + 1'b1;
            aux_rnext   <= aux;
            if (id_cnt_ff != sfr_pkg::ID_MAX_BYTES) begin
              id_cnt_ff <= id_cnt_ff + 3'h1;
            end
          end else begin
            so_out      <= out_byte_ff[7];
            out_byte_ff <= {out_byte_ff[6:0], 1'b0};
          end
        end else if (dual) begin
          so_oe               <= 1'b1;
          second_data_line_oe <= 1'b1;
          // In dual mode bit_cnt_ff steps by one per clock; two low bits pick the pair.
          if (bit_cnt_ff[1:0] == 2'h0) begin
            so_out               <= array_data[7];
            second_data_line_out <= array_data[6];
            out_byte_ff          <= {array_data[5:0], 2'h0};
            addr_ff              <= addr_ff + 1'b1;
          end else begin
            so_out               <= out_byte_ff[7];
            second_data_line_out <= out_byte_ff[6];
            out_byte_ff          <= {out_byte_ff[5:0], 2'h0};
          end
        end
      end
    end
  end

  // Wrap is natural: the counter is exactly as wide as the array.
  assign array_addr = addr_ff;

endmodule

//--- verilog/sfr_pkg.sv
// Constants for the serial flash command and read front end.
package sfr_pkg;
  localparam int ADDR_W = 21;
  localparam logic [7:0] OP_READ_FAST  = 8'h1b;
  localparam logic [7:0] OP_READ_STD   = 8'h0b;
  localparam logic [7:0] OP_READ_SLOW  = 8'h03;
  localparam logic [7:0] OP_READ_DUAL  = 8'h3b;
  localparam logic [7:0] OP_PAGE_PROG  = 8'h02;
  localparam logic [7:0] OP_DUAL_PROG  = 8'ha2;
  localparam logic [7:0] OP_WR_STAT1   = 8'h01;
  localparam logic [7:0] OP_WR_STAT2   = 8'h31;
  localparam logic [7:0] OP_RD_STAT    = 8'h05;
  localparam logic [7:0] OP_OTP_READ   = 8'h77;
  localparam logic [7:0] OP_OTP_PROG   = 8'h9b;
  localparam logic [7:0] OP_RD_PROT    = 8'h3c;
  localparam logic [7:0] OP_RD_LOCK    = 8'h35;
  localparam logic [7:0] OP_LOCKDOWN   = 8'h33;
  localparam logic [7:0] OP_FREEZE     = 8'h34;
  localparam logic [7:0] OP_PROTECT    = 8'h36;
  localparam logic [7:0] OP_UNPROTECT  = 8'h39;
  localparam logic [7:0] OP_ERASE_4K   = 8'h20;
  localparam logic [7:0] OP_ERASE_32K  = 8'h52;
  localparam logic [7:0] OP_ERASE_64K  = 8'hd8;
  localparam logic [7:0] OP_CHIP_ER_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ER_B  = 8'hc7;
  localparam logic [7:0] OP_SUSPEND    = 8'hb0;
  localparam logic [7:0] OP_RESUME     = 8'hd0;
  localparam logic [7:0] OP_WR_EN      = 8'h06;
  localparam logic [7:0] OP_WR_DIS     = 8'h04;
  localparam logic [7:0] OP_SOFT_RESET = 8'hf0;
  localparam logic [7:0] OP_READ_ID    = 8'h9f;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_POWER_UP   = 8'hab;
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam logic [1:0] ADDR_BYTES    = 2'h3;
  localparam logic [1:0] DUMMY_NONE    = 2'h0;
  localparam logic [1:0] DUMMY_ONE     = 2'h1;
  localparam logic [1:0] DUMMY_TWO     = 2'h2;
  localparam logic [2:0] IDLE_LEN      = 3'h0;
  localparam logic [2:0] ID_MAX_BYTES  = 3'h4;
  typedef enum logic [2:0] {
    SFR_SETUP_IDLE,
    SFR_SETUP_OPCODE,
    SFR_SETUP_ADDR,
    SFR_SETUP_DUMMY,
    SFR_SETUP_DATA,
    SFR_SETUP_IGNORE
  } sfr_phase_e;
  typedef enum logic [2:0] {
    SFR_KIND_NONE,
    SFR_KIND_READ,
    SFR_KIND_DUAL,
    SFR_KIND_WRITE,
    SFR_KIND_AUX_RD,
    SFR_KIND_BARE
  } sfr_kind_e;
endpackage

//--- tb/sfr_front_sva.sv
// Concurrent checks on the pins of the serial flash front end.
`timescale 1ns/100ps
module sfr_front_sva #(
  parameter int ADDR_W = 21
) (
  // Clock and reset.
  input wire logic              clk,
  input wire logic              rst_b,
  // SPI pins.
  input wire logic              cs_b_pin,
  input wire logic              sck_pin,
  input wire logic              so_out,
  input wire logic              so_oe,
  input wire logic              second_data_line_oe,
  // Array and command side.
  input wire logic [ADDR_W-1:0] array_addr,
  input wire logic [7:0]        cmd_opcode,
  input wire logic              cmd_start,
  input wire logic              cmd_wvalid,
  input wire logic              cmd_end
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  so_float_a: assert property (cs_b_pin [*8] |-> !so_oe)
    else $error("serial output still driven after deselect");
  sdl_float_a: assert property (cs_b_pin [*8] |-> !second_data_line_oe)
    else $error("second data line still driven after deselect");
  sdl_dual_a: assert property (second_data_line_oe |-> cmd_opcode == 8'h3b)
    else $error("second data line driven outside dual read");
  so_hold_a: assert property ((!cs_b_pin && sck_pin) [*4] |-> $stable(so_out))
    else $error("serial output changed while the serial clock was high");
  addr_step_a: assert property (so_oe && $past(so_oe) && array_addr != $past(array_addr)
    |-> array_addr == $past(array_addr) + 1'b1)
    else $error("array address did not step by one");
  start_pulse_a: assert property (cmd_start |=> !cmd_start)
    else $error("command start longer than one cycle");
  start_known_a: assert property (cmd_start |-> cmd_opcode inside {8'h1b, 8'h0b, 8'h03,
    8'h3b, 8'h02, 8'ha2, 8'h01, 8'h31, 8'h05, 8'h77, 8'h9b, 8'h3c, 8'h35, 8'h33, 8'h34,
    8'h36, 8'h39, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'hb0, 8'hd0, 8'h06, 8'h04, 8'hf0,
    8'h9f, 8'hb9, 8'hab})
    else $error("command started for an unknown opcode");
  wvalid_kind_a: assert property (cmd_wvalid |-> cmd_opcode inside {8'h02, 8'ha2,
    8'h9b, 8'h01, 8'h31, 8'h33, 8'h34, 8'hf0})
    else $error("write byte flagged for a non-write command");
  end_pulse_a: assert property (cmd_end |-> cs_b_pin ##1 !cmd_end)
    else $error("command end not a single pulse after deselect");
  oe_read_a: assert property ($rose(so_oe) |-> cmd_opcode inside {8'h03, 8'h0b, 8'h1b,
    8'h3b, 8'h05, 8'h77, 8'h3c, 8'h35, 8'h9f})
    else $error("serial output enabled for a command without read data");
endmodule
bind sfr_front sfr_front_sva #(.ADDR_W(ADDR_W)) u_sfr_front_sva (.clk(clk), .rst_b(rst_b),
  .cs_b_pin(cs_b_pin), .sck_pin(sck_pin), .so_out(so_out), .so_oe(so_oe),
  .second_data_line_oe(second_data_line_oe), .array_addr(array_addr),
  .cmd_opcode(cmd_opcode), .cmd_start(cmd_start), .cmd_wvalid(cmd_wvalid),
  .cmd_end(cmd_end));

//--- tb/sfr_host_model.sv
// Behavioural SPI master driving the flash pins in mode 0.
`timescale 1ns/100ps
module sfr_host_model #(
  parameter int HALF = 8
) (
  // Clock.
  input  wire logic clk,
  // Pins towards the device.
  output logic      cs_b_pin,
  output logic      sck_pin,
  output logic      host_si,
  // Pins from the device.
  input  wire logic so_out,
  input  wire logic second_data_line_out
);
  initial begin
    cs_b_pin = 1'b1;
    sck_pin  = 1'b0;
    host_si  = 1'b0;
  end
  task automatic sel();
    repeat (HALF) @(negedge clk);
    cs_b_pin = 1'b0;
    repeat (HALF) @(negedge clk);
  endtask
  // The clock stands low between frames; the released input line is inverted so it never
  // looks like a held bit.
  task automatic desel();
    @(negedge clk);
    cs_b_pin = 1'b1;
    host_si  = ~host_si;
    repeat (2*HALF) @(negedge clk);
  endtask
  // Launch on the falling edge, sample just before the rising edge.
  task automatic xbyte(input logic [7:0] b, input logic dual, input int nb,
                       output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < nb; i++) begin
      host_si = dual ? ~host_si : b[7-i];
      repeat (HALF) @(negedge clk);
      if (dual) r[7-2*i -: 2] = {so_out, second_data_line_out};
      else r[7-i] = so_out;
      sck_pin = 1'b1;
      repeat (HALF) @(negedge clk);
      sck_pin = 1'b0;
    end
  endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench for the serial flash command and read front end.
`timescale 1ns/100ps
module testbench;
  logic                       clk, rst_b, clk_en, cs_b_pin, sck_pin, host_si, si_pin;
  logic                       so_out, so_oe, second_data_line_out, second_data_line_oe;
  logic [sfr_pkg::ADDR_W-1:0] array_addr;
  logic [7:0]                 array_data, cmd_opcode, cmd_wdata, aux_rdata, r;
  logic [23:0]                cmd_addr;
  logic                       cmd_start, cmd_wvalid, cmd_end, aux_rnext;
  int                         errors, checks, n_start, n_wvalid, n_end;
  function automatic logic [7:0] mem(input logic [20:0] a);
    return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
  endfunction
  // The shared pin carries the device's bit only while it drives it.
  assign si_pin     = second_data_line_oe ? second_data_line_out : host_si;
  assign array_data = mem(array_addr);
  sfr_front u_sfr_front (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .cs_b_pin(cs_b_pin),
    .sck_pin(sck_pin), .si_pin(si_pin), .so_out(so_out), .so_oe(so_oe),
    .second_data_line_out(second_data_line_out), .second_data_line_oe(second_data_line_oe),
    .array_addr(array_addr), .array_data(array_data), .cmd_opcode(cmd_opcode),
    .cmd_addr(cmd_addr), .cmd_start(cmd_start), .cmd_wdata(cmd_wdata),
    .cmd_wvalid(cmd_wvalid), .cmd_end(cmd_end), .aux_rdata(aux_rdata), .aux_rnext(aux_rnext));
  sfr_host_model u_sfr_host_model (.clk(clk), .cs_b_pin(cs_b_pin), .sck_pin(sck_pin),
    .host_si(host_si), .so_out(so_out), .second_data_line_out(second_data_line_out));
  always @(posedge clk) begin
    if (cmd_start === 1'b1) n_start++;
    if (cmd_wvalid === 1'b1) n_wvalid++;
    if (cmd_end === 1'b1) n_end++;
    if (aux_rnext === 1'b1) aux_rdata <= aux_rdata + 8'h11;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic head(input logic [7:0] op, input logic [23:0] a, input int na, input int nd);
    u_sfr_host_model.sel();
    u_sfr_host_model.xbyte(op, 1'b0, 8, r);
    for (int i = 0; i < na; i++) u_sfr_host_model.xbyte(a[23-8*i -: 8], 1'b0, 8, r);
    for (int i = 0; i < nd; i++) u_sfr_host_model.xbyte(8'ha5, 1'b0, 8, r);
  endtask
  task automatic t_read();
    logic [7:0]  ops [3] = '{8'h03, 8'h0b, 8'h1b};
    logic [20:0] a;
    int          s;
    for (int k = 0; k < 3; k++) begin
      s = n_start + n_end;
      a = 21'h1ffffe;
      head(ops[k], 24'hfffffe, 3, k);
      chk("address", cmd_addr, 24'hfffffe);
      for (int j = 0; j < 3; j++) begin
        u_sfr_host_model.xbyte(8'h00, 1'b0, 8, r);
        chk("read byte", r, mem(a));
        a = a + 1'b1;
      end
      u_sfr_host_model.xbyte(8'h00, 1'b0, 3, r);
      u_sfr_host_model.desel();
      chk("so release", so_oe, 1'b0);
      chk("start and end", n_start + n_end - s, 2);
    end
    $display("TB: read test done");
  endtask
  task automatic t_dual();
    logic [20:0] a = 21'h0abcde;
    head(8'h3b, 24'h0abcde, 3, 1);
    for (int j = 0; j < 2; j++) begin
      u_sfr_host_model.xbyte(8'h00, 1'b1, 4, r);
      chk("dual byte", r, mem(a));
      a = a + 1'b1;
    end
    u_sfr_host_model.xbyte(8'h00, 1'b1, 2, r);
    u_sfr_host_model.desel();
    chk("dual release", {so_oe, second_data_line_oe}, 2'b00);
    $display("TB: dual test done");
  endtask
  task automatic t_refuse();
    int s = n_start;
    int e = n_end;
    head(8'hff, 24'h000100, 3, 1);
    chk("ignored output", so_oe, 1'b0);
    u_sfr_host_model.desel();
    chk("no end", n_end - e, 0);
    head(8'h03, 24'h000100, 1, 0);
    u_sfr_host_model.desel();
    chk("no start", n_start - s, 0);
    head(8'h03, 24'h000100, 3, 0);
    u_sfr_host_model.xbyte(8'h00, 1'b0, 8, r);
    chk("read after abort", r, mem(21'h000100));
    u_sfr_host_model.desel();
    $display("TB: refuse test done");
  endtask
  task automatic t_cmds();
    logic [7:0] wop [4] = '{8'h02, 8'h9b, 8'h34, 8'h01};
    logic [7:0] aop [4] = '{8'h77, 8'h3c, 8'h35, 8'h9f};
    logic [7:0] bop [2] = '{8'hab, 8'hb9};
    int         s;
    for (int k = 0; k < 4; k++) begin
      s = n_wvalid;
      head(wop[k], 24'h001234, k < 3 ? 3 : 0, 0);
      // Program commands get two bytes; freeze and status write take exactly one.
      for (int j = 0; j < 2 - k / 2; j++) u_sfr_host_model.xbyte(8'h5a + j, 1'b0, 8, r);
      chk("write bytes", n_wvalid - s, 2 - k / 2);
      chk("write data", cmd_wdata, 8'h5b - k / 2);
      u_sfr_host_model.desel();
      aux_rdata = 8'h30 + k;
      head(aop[k], 24'h000040, k < 3 ? 3 : 0, k == 0 ? 2 : 0);
      for (int j = 0; j < 2; j++) begin
        u_sfr_host_model.xbyte(8'h00, 1'b0, 8, r);
        chk("aux byte", r, 8'h30 + k + 8'h11 * j);
      end
      u_sfr_host_model.desel();
    end
    for (int k = 0; k < 2; k++) begin
      s = n_start;
      head(bop[k], 24'h0, 0, 0);
      u_sfr_host_model.desel();
      chk("bare opcode", cmd_opcode, bop[k]);
      chk("bare start", n_start - s, 1);
    end
    $display("TB: command test done");
  endtask
  task automatic end_sim();
    $display("TB: checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst_b     = 1'b0;
    clk_en    = 1'b1;
    aux_rdata = 8'h00;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    t_read();
    t_dual();
    t_refuse();
    t_cmds();
    end_sim();
  end
  // The tests need about 12000 cycles; this cuts a hang well beyond that.
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule
